// ---- rtl/tmf_cfg.svh ----
// constants for the test mode forcing block
`ifndef TMF_CFG_SVH
`define TMF_CFG_SVH
// channel counts and bus widths
`define TMF_NUM_CIN   16
`define TMF_NUM_COUT  16
`define TMF_NUM_VIRT  32
`define TMF_NUM_REM   32
`define TMF_NUM_DIR   16
`define TMF_AW        8
`define TMF_DW        32
// register byte offsets
`define TMF_OFF_CTRL     8'h00
`define TMF_OFF_STATUS   8'h04
`define TMF_OFF_IN_FRC   8'h08
`define TMF_OFF_OUT_FRC  8'h0c
`define TMF_OFF_CIN      8'h10
`define TMF_OFF_COUT     8'h14
`define TMF_OFF_VIRT     8'h18
`define TMF_OFF_REM      8'h1c
`define TMF_OFF_REM_DEF  8'h20
`define TMF_OFF_DIR      8'h24
`define TMF_OFF_DIR_DEF  8'h28
// field positions
`define TMF_CTRL_EN_BIT  0
`define TMF_CTRL_ON_BIT  1
`define TMF_STAT_ACT_BIT 0
`define TMF_STAT_LED_BIT 1
// reset values
`define TMF_CTRL_RST     2'h0
`define TMF_FRC_RST      32'h0000_0000
`define TMF_DEF_RST      32'h0000_0000
`define TMF_WORD_ZERO    32'h0000_0000
// timing
`define TMF_CLK_HZ       200000000
`define TMF_MS_PER_S     1000
`define TMF_FLASH_HALF_MS 250
`define TMF_FLASH_W      26
`endif

// ---- rtl/tmf_pkg.sv ----
// types for the test mode forcing block
package tmf_pkg;
  // test mode state, one-hot
  typedef enum logic [1:0] {
    TMF_NORMAL = 2'b01,
    TMF_TEST   = 2'b10
  } tmf_state_t;
  // contact input force selection
  typedef enum logic [1:0] {
    TMF_IN_DIS    = 2'h0,
    TMF_IN_OPEN   = 2'h1,
    TMF_IN_CLOSED = 2'h2,
    TMF_IN_RSV    = 2'h3
  } tmf_in_force_t;
  // contact output force selection
  typedef enum logic [1:0] {
    TMF_OUT_DIS    = 2'h0,
    TMF_OUT_ENERG  = 2'h1,
    TMF_OUT_DEENRG = 2'h2,
    TMF_OUT_FREEZE = 2'h3
  } tmf_out_force_t;
  // control register fields
  typedef struct packed {
    logic init_on;  // initiator held at logic 1
    logic enable;   // test function enabled
  } tmf_ctrl_t;
endpackage : tmf_pkg

// ---- rtl/tmf_sync.sv ----
// two-flop synchroniser for the contact input pins
`timescale 1ns/10ps
`default_nettype none
`include "tmf_cfg.svh"
module tmf_sync
  import tmf_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [`TMF_NUM_CIN-1:0]  din,
  output var  logic [`TMF_NUM_CIN-1:0]  dout
);
  logic [`TMF_NUM_CIN-1:0] meta_reg;  // first stage, read only by second
  // one synchroniser per pin
  for (genvar i = 0; i < `TMF_NUM_CIN; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_reg[i] <= 1'b0;
        dout[i]     <= 1'b0;
      end else begin
        meta_reg[i] <= din[i];
        dout[i]     <= meta_reg[i];
      end
    end
  end
endmodule : tmf_sync
`default_nettype wire

// ---- rtl/tmf_flash.sv ----
// flashing driver for the test indicator
`timescale 1ns/10ps
`default_nettype none
`include "tmf_cfg.svh"
module tmf_flash
  import tmf_pkg::*;
#(
  parameter logic [`TMF_FLASH_W-1:0] HALF_CYC = `TMF_FLASH_W'd1
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output var  logic led
);
  logic [`TMF_FLASH_W-1:0] cnt_reg;  // cycles into current half period
  logic                    run_reg;  // run as seen one cycle ago
  // remember run so the first test cycle can be told apart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= run;
    end
  end
  // half-period counter, parked at zero outside test mode and restarted
  // on entry so the first lit half is as long as every later one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!run || !run_reg || cnt_reg == HALF_CYC - 1'b1) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  // lamp starts lit so entry is visible at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led <= 1'b0;
    end else if (!run) begin
      led <= 1'b0;
    end else if (!run_reg) begin
      led <= 1'b1;
    end else if (cnt_reg == HALF_CYC - 1'b1) begin
      led <= ~led;
    end
  end
endmodule : tmf_flash
`default_nettype wire

// ---- rtl/tmf_top.sv ----
// test mode control and contact forcing, top level
// What this block does
// - test mode needs enable and initiator at 1
// - flash front test indicator during test mode
// - other logic paths untouched by test mode
// - disabled input force reports sensed terminal state
// - open input force reports 0 in test
// - closed input force reports 1 in test
// - all forces disabled gives normal input sensing
// - disabled output force follows its operand
// - energize output force drives closed in test
// - de-energize output force drives open in test
// - freeze output holds drive captured at entry
// - every input and output has own selection
// - status on reads 1, off reads 0
// - report state of all 32 virtual inputs
// - remote input shows default while device offline
// - direct input shows default while channel failed
`timescale 1ns/10ps
`default_nettype none
`include "tmf_cfg.svh"
module tmf_top
  import tmf_pkg::*;
#(
  // cycles per half flash period; shorten in simulation
  parameter int unsigned FLASH_HALF_CYC =
    `TMF_FLASH_HALF_MS * (`TMF_CLK_HZ / `TMF_MS_PER_S)
)(
  input  wire logic                       CLOCK,
  input  wire logic                       RST,
  input  wire logic [`TMF_AW-1:0]         BUS_ADDR,
  input  wire logic [`TMF_DW-1:0]         BUS_WDATA,
  input  wire logic                       BUS_WR,
  input  wire logic                       BUS_RD,
  output var  logic [`TMF_DW-1:0]         BUS_RDATA,
  input  wire logic                       TEST_INITIATE,
  input  wire logic [`TMF_NUM_CIN-1:0]    CONTACT_IN_PIN,
  output var  logic [`TMF_NUM_CIN-1:0]    CONTACT_INPUT_STATE,
  input  wire logic [`TMF_NUM_COUT-1:0]   OUTPUT_OPERAND,
  output var  logic [`TMF_NUM_COUT-1:0]   CONTACT_OUT_DRIVE,
  output var  logic                       TEST_LED,
  output var  logic                       TEST_ACTIVE,
  input  wire logic [`TMF_NUM_VIRT-1:0]   VIRTUAL_INPUT,
  input  wire logic [`TMF_NUM_REM-1:0]    REMOTE_VALUE,
  input  wire logic [`TMF_NUM_REM-1:0]    REMOTE_OFFLINE,
  input  wire logic [2*`TMF_NUM_DIR-1:0]  DIRECT_VALUE,
  input  wire logic [1:0]                 CHANNEL_FAILED
);

  // register state
  tmf_ctrl_t                  ctrl_reg;     // enable and initiator source
  logic [2*`TMF_NUM_CIN-1:0]  in_frc_reg;   // two bits per contact input
  logic [2*`TMF_NUM_COUT-1:0] out_frc_reg;  // two bits per contact output
  logic [`TMF_NUM_REM-1:0]    rem_def_reg;  // remote input defaults
  logic [2*`TMF_NUM_DIR-1:0]  dir_def_reg;  // direct input defaults
  // block state
  tmf_state_t                 state_reg;    // normal or test
  tmf_state_t                 state_next;
  logic [`TMF_NUM_COUT-1:0]   frozen_reg;   // drive captured at entry
  logic [`TMF_NUM_VIRT-1:0]   virt_reg;     // virtual input snapshot
  logic [`TMF_NUM_REM-1:0]    rem_reg;      // reported remote states
  logic [2*`TMF_NUM_DIR-1:0]  dir_reg;      // reported direct states
  logic [`TMF_NUM_CIN-1:0]    cin_sync;     // pins after synchroniser
  logic                       initiator;    // selected initiating operand
  logic                       in_test;      // test mode in force
  logic                       entering;     // last cycle before test mode
  logic                       led;          // flasher output
  logic [`TMF_NUM_COUT-1:0]   drive_next;   // next contact output drive
  logic [`TMF_NUM_CIN-1:0]    cin_next;     // next reported input state
  logic [`TMF_DW-1:0]         rdata_next;   // read mux result

  // contact pins come from outside the clock domain
  // a bounce shorter than one clock may be missed; contacts are far slower
  tmf_sync u_sync (
    .clk  (CLOCK),
    .rst  (RST),
    .din  (CONTACT_IN_PIN),
    .dout (cin_sync)
  );

  // indicator flashes only while test mode holds
  // the divider is long in hardware, so the bench shortens it by parameter
  tmf_flash #(
    .HALF_CYC (FLASH_HALF_CYC[`TMF_FLASH_W-1:0])
  ) u_flash (
    .clk (CLOCK),
    .rst (RST),
    .run (in_test),
    .led (led)
  );

  // initiator is either held on by setting or the live operand
  assign initiator = ctrl_reg.init_on | TEST_INITIATE;

  // level qualifies: rising operand or late enable both start test
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TMF_NORMAL: begin
        // a held initiator followed by a late enable also lands here
        if (ctrl_reg.enable && initiator) begin
          state_next = TMF_TEST;
        end
      end
      TMF_TEST: begin
        // either condition dropping ends test mode
        if (!(ctrl_reg.enable && initiator)) begin
          state_next = TMF_NORMAL;
        end
      end
      default: begin
        state_next = TMF_NORMAL;
      end
    endcase
  end

  // test mode state register
  // reset always lands in normal mode, so no contact is forced at power up
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_reg <= TMF_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // entry is seen one cycle early, so the freeze snapshot takes the operand-driven
  // drive of the cycle before the entering edge, before any forcing reaches the contacts
  assign in_test  = (state_reg == TMF_TEST);
  assign entering = (state_next == TMF_TEST) && !in_test;

  // freeze snapshot: taken once, from the drive seen before entry
  // the snapshot is kept after exit but only read while frozen in test
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      frozen_reg <= '0;
    end else if (entering) begin
      frozen_reg <= CONTACT_OUT_DRIVE;
    end
  end

  // per-channel forcing; each channel reads only its own field
  for (genvar i = 0; i < `TMF_NUM_CIN; i++) begin : g_cin
    tmf_in_force_t sel;
    assign sel = tmf_in_force_t'(in_frc_reg[2*i +: 2]);
    always_comb begin
      cin_next[i] = cin_sync[i];
      if (in_test) begin
        case (sel)
          TMF_IN_OPEN:   cin_next[i] = 1'b0;
          TMF_IN_CLOSED: cin_next[i] = 1'b1;
          default:       cin_next[i] = cin_sync[i];
        endcase
      end
    end
  end

  for (genvar j = 0; j < `TMF_NUM_COUT; j++) begin : g_cout
    tmf_out_force_t sel;
    assign sel = tmf_out_force_t'(out_frc_reg[2*j +: 2]);
    always_comb begin
      drive_next[j] = OUTPUT_OPERAND[j];
      if (in_test) begin
        case (sel)
          TMF_OUT_ENERG:  drive_next[j] = 1'b1;
          TMF_OUT_DEENRG: drive_next[j] = 1'b0;
          TMF_OUT_FREEZE: drive_next[j] = frozen_reg[j];
          default:        drive_next[j] = OUTPUT_OPERAND[j];
        endcase
      end
    end
  end

  // contact input and output registers; normal paths resume as soon
  // as in_test drops, so no stale forced value outlives the test
  // one register stage also keeps decode glitches off the contact drivers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CONTACT_INPUT_STATE <= '0;
      CONTACT_OUT_DRIVE   <= '0;
    end else begin
      CONTACT_INPUT_STATE <= cin_next;
      CONTACT_OUT_DRIVE   <= drive_next;
    end
  end

  // indicator and active flag are registered for clean pins
  // TEST_ACTIVE therefore trails the internal state by one cycle
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      TEST_LED    <= 1'b0;
      TEST_ACTIVE <= 1'b0;
    end else begin
      TEST_LED    <= led;
      TEST_ACTIVE <= in_test;
    end
  end

  // communication-based states ignore test mode entirely
  // each value is registered once, so one status read sees one cycle
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      virt_reg <= '0;
      rem_reg  <= '0;
      dir_reg  <= '0;
    end else begin
      virt_reg <= VIRTUAL_INPUT;
      // offline source device substitutes the programmed default
      rem_reg  <= (REMOTE_VALUE & ~REMOTE_OFFLINE)
                | (rem_def_reg & REMOTE_OFFLINE);
      // a failed channel substitutes its whole default group
      dir_reg[`TMF_NUM_DIR-1:0] <= CHANNEL_FAILED[0] ?
        dir_def_reg[`TMF_NUM_DIR-1:0] :
        DIRECT_VALUE[`TMF_NUM_DIR-1:0];
      dir_reg[2*`TMF_NUM_DIR-1:`TMF_NUM_DIR] <= CHANNEL_FAILED[1] ?
        dir_def_reg[2*`TMF_NUM_DIR-1:`TMF_NUM_DIR] :
        DIRECT_VALUE[2*`TMF_NUM_DIR-1:`TMF_NUM_DIR];
    end
  end

  // control register; setting the initiator first lets enable start test
  // a write of zero ends test mode at the next edge
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= tmf_ctrl_t'(`TMF_CTRL_RST);
    end else if (BUS_WR && BUS_ADDR == `TMF_OFF_CTRL) begin
      ctrl_reg.enable  <= BUS_WDATA[`TMF_CTRL_EN_BIT];
      ctrl_reg.init_on <= BUS_WDATA[`TMF_CTRL_ON_BIT];
    end
  end

  // force selections may change mid test and take effect at once
  // a reserved input code reads back as written but acts as disabled
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      in_frc_reg  <= `TMF_FRC_RST;
      out_frc_reg <= `TMF_FRC_RST;
    end else if (BUS_WR) begin
      if (BUS_ADDR == `TMF_OFF_IN_FRC) begin
        in_frc_reg <= BUS_WDATA;
      end
      if (BUS_ADDR == `TMF_OFF_OUT_FRC) begin
        out_frc_reg <= BUS_WDATA;
      end
    end
  end

  // default states for communication inputs
  // defaults apply only while a source is offline or a channel has failed
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rem_def_reg <= `TMF_DEF_RST;
      dir_def_reg <= `TMF_DEF_RST;
    end else if (BUS_WR) begin
      if (BUS_ADDR == `TMF_OFF_REM_DEF) begin
        rem_def_reg <= BUS_WDATA;
      end
      if (BUS_ADDR == `TMF_OFF_DIR_DEF) begin
        dir_def_reg <= BUS_WDATA;
      end
    end
  end

  // read mux; on reads 1 and off reads 0 everywhere
  // unmapped addresses fall to zero, so probing the map is harmless
  always_comb begin
    rdata_next = `TMF_WORD_ZERO;
    case (BUS_ADDR)
      `TMF_OFF_CTRL: begin
        rdata_next[`TMF_CTRL_EN_BIT] = ctrl_reg.enable;
        rdata_next[`TMF_CTRL_ON_BIT] = ctrl_reg.init_on;
      end
      `TMF_OFF_STATUS: begin
        rdata_next[`TMF_STAT_ACT_BIT] = in_test;
        rdata_next[`TMF_STAT_LED_BIT] = TEST_LED;
      end
      `TMF_OFF_IN_FRC:  rdata_next = in_frc_reg;
      `TMF_OFF_OUT_FRC: rdata_next = out_frc_reg;
      `TMF_OFF_CIN: begin
        rdata_next[`TMF_NUM_CIN-1:0] = CONTACT_INPUT_STATE;
      end
      `TMF_OFF_COUT: begin
        rdata_next[`TMF_NUM_COUT-1:0] = CONTACT_OUT_DRIVE;
      end
      `TMF_OFF_VIRT:    rdata_next = virt_reg;
      `TMF_OFF_REM:     rdata_next = rem_reg;
      `TMF_OFF_REM_DEF: rdata_next = rem_def_reg;
      `TMF_OFF_DIR:     rdata_next = dir_reg;
      `TMF_OFF_DIR_DEF: rdata_next = dir_def_reg;
      default:          rdata_next = `TMF_WORD_ZERO;
    endcase
  end

  // read data valid only in the cycle after the strobe
  // zero outside that cycle keeps a shared return path quiet
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      BUS_RDATA <= `TMF_WORD_ZERO;
    end else if (BUS_RD) begin
      BUS_RDATA <= rdata_next;
    end else begin
      BUS_RDATA <= `TMF_WORD_ZERO;
    end
  end

endmodule : tmf_top
`default_nettype wire

// ---- tb/tmf_ext.sv ----
// far side model: contact circuits and protection operands
`timescale 1ns/10ps
`default_nettype none
module tmf_ext (
  input  wire logic        clk,
  input  wire logic [15:0] pin_set,
  input  wire logic [15:0] op_set,
  output var  logic [15:0] pin,
  output var  logic [15:0] operand
);
  // both start open so nothing floats before the first edge
  initial begin
    pin = 16'h0;
    operand = 16'h0;
  end
  // terminal voltages and operands settle one cycle after a command
  always @(posedge clk) begin
    pin <= pin_set;
    operand <= op_set;
  end
endmodule : tmf_ext
`default_nettype wire

// ---- tb/tmf_top_asserts.sv ----
// port checker for the test mode forcing top
`timescale 1ns/10ps
`default_nettype none
`include "tmf_cfg.svh"
module tmf_chk
  import tmf_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC = 4
)(
  input wire logic                     CLOCK,
  input wire logic                     RST,
  input wire logic [`TMF_AW-1:0]       BUS_ADDR,
  input wire logic [`TMF_DW-1:0]       BUS_WDATA,
  input wire logic                     BUS_WR,
  input wire logic                     BUS_RD,
  input wire logic [`TMF_DW-1:0]       BUS_RDATA,
  input wire logic                     TEST_INITIATE,
  input wire logic [`TMF_NUM_CIN-1:0]  CONTACT_IN_PIN,
  input wire logic [`TMF_NUM_CIN-1:0]  CONTACT_INPUT_STATE,
  input wire logic [`TMF_NUM_COUT-1:0] OUTPUT_OPERAND,
  input wire logic [`TMF_NUM_COUT-1:0] CONTACT_OUT_DRIVE,
  input wire logic                     TEST_LED,
  input wire logic                     TEST_ACTIVE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic [1:0]  ctrl_reg;  // shadow of the control word
  logic [31:0] ifrc_reg;  // shadow of input force selections
  logic [31:0] ofrc_reg;  // shadow of output force selections
  logic [31:0] cnt_reg;   // cycles the indicator has held still
  logic [15:0] opn, cls, dis, enr, den, frz;
  wire         cond = ctrl_reg[0] & (ctrl_reg[1] | TEST_INITIATE);
  // shadows follow the bus so forcing can be predicted per channel
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= 2'h0;
      ifrc_reg <= 32'h0;
      ofrc_reg <= 32'h0;
    end else if (BUS_WR) begin
      if (BUS_ADDR == `TMF_OFF_CTRL) ctrl_reg <= BUS_WDATA[1:0];
      if (BUS_ADDR == `TMF_OFF_IN_FRC) ifrc_reg <= BUS_WDATA;
      if (BUS_ADDR == `TMF_OFF_OUT_FRC) ofrc_reg <= BUS_WDATA;
    end
  end
  // idle count restarts outside test, so entry never looks stuck
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) cnt_reg <= 32'h0;
    else if (!TEST_ACTIVE || $changed(TEST_LED)) cnt_reg <= 32'h0;
    else cnt_reg <= cnt_reg + 32'h1;
  end
  // per channel decode; code 3 on an input acts as disabled
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      opn[i] = ifrc_reg[2*i+:2] == TMF_IN_OPEN;
      cls[i] = ifrc_reg[2*i+:2] == TMF_IN_CLOSED;
      dis[i] = ofrc_reg[2*i+:2] == TMF_OUT_DIS;
      enr[i] = ofrc_reg[2*i+:2] == TMF_OUT_ENERG;
      den[i] = ofrc_reg[2*i+:2] == TMF_OUT_DEENRG;
      frz[i] = ofrc_reg[2*i+:2] == TMF_OUT_FREEZE;
    end
  end
  sequence in_test_s;
    TEST_ACTIVE && $past(TEST_ACTIVE);
  endsequence
  rdata_idle_a: assert property (!BUS_RD |=> BUS_RDATA == 32'h0)
    else $error("read data not zero when idle");
  test_entry_a: assert property (TEST_ACTIVE == $past(cond, 2))
    else $error("test flag does not follow entry condition");
  status_rd_a: assert property (BUS_RD && BUS_ADDR == `TMF_OFF_STATUS |=>
    BUS_RDATA == {30'h0, $past(TEST_LED), TEST_ACTIVE}) else $error("status word wrong");
  in_norm_a: assert property (!TEST_ACTIVE |->
    CONTACT_INPUT_STATE == $past(CONTACT_IN_PIN, 3)) else $error("input not sensed");
  out_norm_a: assert property (!TEST_ACTIVE |->
    CONTACT_OUT_DRIVE == $past(OUTPUT_OPERAND)) else $error("output not on operand");
  in_force_a: assert property (in_test_s |->
    ((CONTACT_INPUT_STATE & $past(opn)) == 16'h0) &&
    ((CONTACT_INPUT_STATE & $past(cls)) == $past(cls))) else $error("input force wrong");
  out_force_a: assert property (in_test_s |->
    ((CONTACT_OUT_DRIVE & $past(den)) == 16'h0) &&
    ((CONTACT_OUT_DRIVE & $past(enr)) == $past(enr)) &&
    (((CONTACT_OUT_DRIVE ^ $past(OUTPUT_OPERAND)) & $past(dis)) == 16'h0))
    else $error("output force wrong");
  freeze_hold_a: assert property (in_test_s |->
    ((CONTACT_OUT_DRIVE ^ $past(CONTACT_OUT_DRIVE)) & $past(frz) & $past(frz, 2)) == 16'h0)
    else $error("frozen output moved");
  led_off_a: assert property (!TEST_ACTIVE ##1 !TEST_ACTIVE |-> !TEST_LED)
    else $error("indicator lit outside test");
  led_run_a: assert property (TEST_ACTIVE && $stable(TEST_LED) |->
    cnt_reg < FLASH_HALF_CYC) else $error("indicator not flashing");
endmodule : tmf_chk
bind tmf_top tmf_chk #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_chk (
  .CLOCK(CLOCK), .RST(RST), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
  .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA),
  .TEST_INITIATE(TEST_INITIATE), .CONTACT_IN_PIN(CONTACT_IN_PIN),
  .CONTACT_INPUT_STATE(CONTACT_INPUT_STATE), .OUTPUT_OPERAND(OUTPUT_OPERAND),
  .CONTACT_OUT_DRIVE(CONTACT_OUT_DRIVE), .TEST_LED(TEST_LED), .TEST_ACTIVE(TEST_ACTIVE));
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the test mode forcing block
`timescale 1ns/10ps
`default_nettype none
`include "tmf_cfg.svh"
module tb
  import tmf_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        init = 1'b0;
  logic [15:0] pin_set = 16'h0;
  logic [15:0] op_set = 16'h0;
  logic [31:0] virt = 32'h0;
  logic [31:0] rval = 32'h0;
  logic [31:0] roff = 32'h0;
  logic [31:0] dval = 32'h0;
  logic [1:0]  cfail = 2'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [15:0] pin, oper, cin, drive;
  logic        led, act;
  int          bad_count = 0;
  int          n_tests = 0;
  // 200 MHz clock
  always #2.5 clock = ~clock;
  tmf_ext ext (.clk(clock), .pin_set(pin_set), .op_set(op_set), .pin(pin), .operand(oper));
  // short flash half period keeps the run brief
  tmf_top #(.FLASH_HALF_CYC(4)) dut (
    .CLOCK(clock), .RST(rst), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr),
    .BUS_RD(rd), .BUS_RDATA(rdata), .TEST_INITIATE(init), .CONTACT_IN_PIN(pin),
    .CONTACT_INPUT_STATE(cin), .OUTPUT_OPERAND(oper), .CONTACT_OUT_DRIVE(drive),
    .TEST_LED(led), .TEST_ACTIVE(act), .VIRTUAL_INPUT(virt), .REMOTE_VALUE(rval),
    .REMOTE_OFFLINE(roff), .DIRECT_VALUE(dval), .CHANNEL_FAILED(cfail));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_act(input logic v);
    repeat (20) begin
      @(posedge clock);
      #1 if (act === v) break;
    end
    chk({31'h0, act}, {31'h0, v});
  endtask : wait_act
  task automatic t_regs;
    rd_reg(`TMF_OFF_CTRL); chk(d, 32'h0);
    rd_reg(`TMF_OFF_IN_FRC); chk(d, 32'h0);
    rd_reg(8'h40); chk(d, 32'h0);
    wr_reg(`TMF_OFF_OUT_FRC, 32'h1234_5678);
    rd_reg(`TMF_OFF_OUT_FRC); chk(d, 32'h1234_5678);
    wr_reg(`TMF_OFF_STATUS, 32'hffff_ffff);
    rd_reg(`TMF_OFF_STATUS); chk(d, 32'h0);
  endtask : t_regs
  task automatic t_normal;
    pin_set <= 16'ha5c3;
    op_set <= 16'h3c5a;
    wr_reg(`TMF_OFF_CTRL, 32'h1);
    repeat (6) @(posedge clock);
    #1 chk({16'h0, cin}, 32'ha5c3);
    chk({16'h0, drive}, 32'h3c5a);
    chk({31'h0, act}, 32'h0);
    rd_reg(`TMF_OFF_CIN); chk(d, 32'ha5c3);
    rd_reg(`TMF_OFF_COUT); chk(d, 32'h3c5a);
  endtask : t_normal
  task automatic t_test;
    int n;
    logic prev;
    n = 0;
    // per byte: disabled, open or energize, closed or off, spare or freeze
    wr_reg(`TMF_OFF_IN_FRC, 32'he4e4_e4e4);
    wr_reg(`TMF_OFF_OUT_FRC, 32'he4e4_e4e4);
    pin_set <= 16'hffff;
    op_set <= 16'h8888;
    repeat (4) @(posedge clock);
    init <= 1'b1;
    wait_act(1'b1);
    rd_reg(`TMF_OFF_STATUS); chk(d & 32'h1, 32'h1);
    op_set <= 16'h5555;
    repeat (6) @(posedge clock);
    #1 chk({16'h0, cin}, 32'hdddd);
    chk({16'h0, drive}, 32'hbbbb);
    pin_set <= 16'h0;
    op_set <= 16'h0;
    // watch the indicator change while test holds: 20 cycles, half period 4
    prev = led;
    repeat (20) begin
      @(posedge clock);
      #1 if (led !== prev) n++;
      prev = led;
    end
    chk(n, 32'h5);
    chk({16'h0, cin}, 32'h4444);
    chk({16'h0, drive}, 32'haaaa);
    wr_reg(`TMF_OFF_IN_FRC, 32'h0);
    pin_set <= 16'h1234;
    repeat (6) @(posedge clock);
    #1 chk({16'h0, cin}, 32'h1234);
    wr_reg(`TMF_OFF_IN_FRC, 32'he4e4_e4e4);
    init <= 1'b0;
    wait_act(1'b0);
    repeat (2) @(posedge clock);
    #1 chk({16'h0, cin}, 32'h1234);
    chk({16'h0, drive}, 32'h0);
    // held-on initiator, then enabling starts test
    wr_reg(`TMF_OFF_CTRL, 32'h2);
    repeat (4) @(posedge clock);
    #1 chk({31'h0, act}, 32'h0);
    wr_reg(`TMF_OFF_CTRL, 32'h3);
    wait_act(1'b1);
    wr_reg(`TMF_OFF_CTRL, 32'h0);
    wait_act(1'b0);
  endtask : t_test
  task automatic t_status;
    @(posedge clock);
    virt <= 32'hdead_beef;
    rval <= 32'h1234_5678;
    roff <= 32'h0000_ffff;
    dval <= 32'hcafe_f00d;
    cfail <= 2'h2;
    wr_reg(`TMF_OFF_REM_DEF, 32'h00ff_00ff);
    wr_reg(`TMF_OFF_DIR_DEF, 32'h1111_2222);
    rd_reg(`TMF_OFF_VIRT); chk(d, 32'hdead_beef);
    rd_reg(`TMF_OFF_REM); chk(d, 32'h1234_00ff);
    rd_reg(`TMF_OFF_DIR); chk(d, 32'h1111_f00d);
    @(posedge clock);
    cfail <= 2'h1;
    roff <= 32'h0;
    repeat (2) @(posedge clock);
    rd_reg(`TMF_OFF_DIR); chk(d, 32'hcafe_2222);
    rd_reg(`TMF_OFF_REM); chk(d, 32'h1234_5678);
  endtask : t_status
  task automatic complete_run;
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // a hang is cut short far beyond the hundred or so cycles needed
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_normal();
    t_test();
    t_status();
    complete_run();
  end
endmodule : tb
`default_nettype wire
